// ---- shared/tid_defs.svh ----
// constants for the transfer instruction decoder: lengths, cycles,
// address windows, status word layout and execution phases
// assumes inclusion by the package and by the decoder module
`ifndef TID_DEFS_SVH
`define TID_DEFS_SVH

// byte register codes
`define TID_R_X 3'h0
`define TID_R_A 3'h1
`define TID_R_E 3'h4
`define TID_R_D 3'h5
`define TID_R_L 3'h6
`define TID_R_H 3'h7

// instruction lengths in bytes
`define TID_LEN1 2'h1
`define TID_LEN2 2'h2
`define TID_LEN3 2'h3

// instruction cycle counts
`define TID_CYC4 4'h4
`define TID_CYC6 4'h6
`define TID_CYC8 4'h8

// short-direct window
`define TID_SADDR_LO 16'hfe20
`define TID_SADDR_HI 16'hff1f

// vector table window base
`define TID_VEC_BASE 16'h0040

// special register page
`define TID_SFR_PAGE 8'hff

// status word flag positions and reset value
`define TID_PSW_Z 6
`define TID_PSW_HC 4
`define TID_PSW_CY 0
`define TID_PSW_RST 8'h02

// execution phases, counted from the first cycle after acceptance
`define TID_PH_FIRST 4'h1
`define TID_PH_REQ 4'h1
`define TID_PH_DATA 4'h3
`define TID_PH_WB 4'h3
`define TID_CNT_ONE 4'h1

`endif

// ---- shared/tid_pkg.sv ----
// types for the transfer instruction decoder
// assumes tid_defs.svh is on the include path
package tid_pkg;
  `include "tid_defs.svh"

  typedef enum logic [4:0] {
    OP_MOV_R_IMM, OP_MOV_SADDR_IMM, OP_MOV_SFR_IMM,
    OP_MOV_A_R, OP_MOV_R_A, OP_MOV_A_SADDR, OP_MOV_SADDR_A,
    OP_MOV_A_SFR, OP_MOV_SFR_A, OP_MOV_A_ABS, OP_MOV_ABS_A,
    OP_MOV_PSW_IMM, OP_MOV_A_PSW, OP_MOV_PSW_A,
    OP_MOV_A_DE, OP_MOV_DE_A, OP_MOV_A_HL, OP_MOV_HL_A,
    OP_MOV_A_HLB, OP_MOV_HLB_A,
    OP_XCH_A_X, OP_XCH_A_R, OP_XCH_A_SADDR, OP_XCH_A_SFR,
    OP_XCH_A_DE, OP_XCH_A_HL, OP_XCH_A_HLB,
    OP_MOVW_RP_IMM
  } tid_op_t;

  typedef enum logic {ST_IDLE, ST_EXEC} tid_state_t;

  typedef logic [2:0] tid_bitpos_t;

  typedef struct packed {
    logic valid;
    tid_op_t op;
    logic [2:0] rsel;
    logic [1:0] rpsel;
    logic [7:0] imm_byte;
    logic [15:0] imm_word;
    logic [15:0] loc;
    logic [7:0] sfr_sel;
    logic [4:0] vec_sel;
    tid_bitpos_t bit_sel;
    logic wide;
  } tid_instr_t;

  typedef struct packed {
    logic req;
    logic we;
    logic sfr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } tid_mem_t;

  typedef logic [7:0][7:0] tid_gpr_t;
endpackage

// ---- src/tid_decoder.sv ----
// transfer and exchange instruction executor with its register file
// assumes a decoded instruction from the fetch stage on i_clk_sys and a
// byte memory port that returns read data the cycle after a request
//
// Summary of operation
// - byte register codes 0..7 select X, A, C, B, E, D, L, H
// - pair codes 0..3 select accumulator pair, BC, pair two, pair three
// - short-direct only FE20H..FF1FH, paired form only even addresses
// - absolute spans whole 16-bit space, even only for word transfers
// - 5-bit vector operand selects even addresses 0040H..007FH
// - immediates are 16-bit word, 8-bit byte, 3-bit bit position
// - each flag is kept, cleared, set, updated or restored per op
// - immediate byte to register, short-direct or special: 3 bytes, 6
// - accumulator with register, short-direct or special: 2 bytes, 4; exchanges 6, except XCH A,X 1 byte 4
// - accumulator with absolute address: 3 bytes, 8 cycles
// - status word writes overwrite Z, AC, CY; immediate form 3/6
// - indirect via pointer pairs 1 byte 6; based form 2 bytes 6; their exchange forms take 8
// - cycle counts are counted in cpu clock cycles
`include "tid_defs.svh"

module tid_decoder (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // instruction in
  input wire tid_pkg::tid_instr_t i_instr,
  output logic o_ready,
  // completion
  output logic o_done,
  output logic o_illegal,
  output logic [1:0] o_len,
  output logic [15:0] o_vec_loc,
  // memory and special register port
  output tid_pkg::tid_mem_t o_mem,
  input wire logic [7:0] i_mem_rdata,
  // architectural state
  output tid_pkg::tid_gpr_t o_gpr,
  output logic [7:0] o_psw
);
  import tid_pkg::*;

  tid_state_t st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [3:0] cyc_reg, cyc_next;
  tid_instr_t cur_reg, cur_next;
  logic [15:0] ea_reg, ea_next;
  logic [7:0] rd_reg, rd_next;
  tid_gpr_t gpr_reg, gpr_next;
  logic [7:0] psw_reg, psw_next;
  tid_mem_t mem_reg, mem_next;
  logic ready_reg, ready_next;
  logic done_reg, done_next;
  logic ill_reg, ill_next;
  logic [1:0] len_reg, len_next;
  logic [15:0] vec_reg, vec_next;

  // byte count per operation
  function automatic logic [1:0] op_len(input tid_op_t op);
    case (op)
      OP_MOV_A_DE, OP_MOV_DE_A, OP_MOV_A_HL, OP_MOV_HL_A,
      OP_XCH_A_X, OP_XCH_A_DE, OP_XCH_A_HL: op_len = `TID_LEN1;
      OP_MOV_R_IMM, OP_MOV_SADDR_IMM, OP_MOV_SFR_IMM, OP_MOV_A_ABS,
      OP_MOV_ABS_A, OP_MOV_PSW_IMM, OP_MOVW_RP_IMM: op_len = `TID_LEN3;
      default: op_len = `TID_LEN2;
    endcase
  endfunction

  // cycle count per operation
  function automatic logic [3:0] op_cyc(input tid_op_t op);
    case (op)
      OP_MOV_A_R, OP_MOV_R_A, OP_MOV_A_SADDR, OP_MOV_SADDR_A,
      OP_MOV_A_SFR, OP_MOV_SFR_A, OP_MOV_A_PSW, OP_MOV_PSW_A,
      OP_XCH_A_X: op_cyc = `TID_CYC4;
      OP_MOV_A_ABS, OP_MOV_ABS_A, OP_XCH_A_DE, OP_XCH_A_HL,
      OP_XCH_A_HLB: op_cyc = `TID_CYC8;
      default: op_cyc = `TID_CYC6;
    endcase
  endfunction

  function automatic logic op_rd(input tid_op_t op);
    case (op)
      OP_MOV_A_SADDR, OP_MOV_A_SFR, OP_MOV_A_ABS, OP_MOV_A_DE,
      OP_MOV_A_HL, OP_MOV_A_HLB, OP_XCH_A_SADDR, OP_XCH_A_SFR,
      OP_XCH_A_DE, OP_XCH_A_HL, OP_XCH_A_HLB: op_rd = 1'b1;
      default: op_rd = 1'b0;
    endcase
  endfunction

  function automatic logic op_wr(input tid_op_t op);
    case (op)
      OP_MOV_SADDR_IMM, OP_MOV_SFR_IMM, OP_MOV_SADDR_A, OP_MOV_SFR_A,
      OP_MOV_ABS_A, OP_MOV_DE_A, OP_MOV_HL_A,
      OP_MOV_HLB_A: op_wr = 1'b1;
      default: op_wr = 1'b0;
    endcase
  endfunction

  function automatic logic op_xmem(input tid_op_t op);
    case (op)
      OP_XCH_A_SADDR, OP_XCH_A_SFR, OP_XCH_A_DE, OP_XCH_A_HL,
      OP_XCH_A_HLB: op_xmem = 1'b1;
      default: op_xmem = 1'b0;
    endcase
  endfunction

  function automatic logic op_sfr(input tid_op_t op);
    case (op)
      OP_MOV_SFR_IMM, OP_MOV_A_SFR, OP_MOV_SFR_A,
      OP_XCH_A_SFR: op_sfr = 1'b1;
      default: op_sfr = 1'b0;
    endcase
  endfunction

  function automatic logic op_saddr(input tid_op_t op);
    case (op)
      OP_MOV_SADDR_IMM, OP_MOV_A_SADDR, OP_MOV_SADDR_A,
      OP_XCH_A_SADDR: op_saddr = 1'b1;
      default: op_saddr = 1'b0;
    endcase
  endfunction

  function automatic logic op_abs(input tid_op_t op);
    op_abs = (op == OP_MOV_A_ABS) || (op == OP_MOV_ABS_A);
  endfunction

  logic accept;
  logic legal;
  logic [15:0] ea_new;
  logic [7:0] rd_val;
  logic [7:0] acc;
  logic [2:0] plo;
  logic [2:0] phi;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    cyc_next = cyc_reg;
    cur_next = cur_reg;
    ea_next = ea_reg;
    rd_next = rd_reg;
    gpr_next = gpr_reg;
    psw_next = psw_reg;
    mem_next = '0;
    done_next = 1'b0;
    ill_next = ill_reg;
    len_next = len_reg;
    vec_next = vec_reg;
    accept = i_instr.valid && ready_reg;
    acc = gpr_reg[`TID_R_A];
    legal = 1'b1;
    ea_new = i_instr.loc;
    plo = 3'h0;
    phi = 3'h0;
    rd_val = (cnt_reg == `TID_PH_DATA) ? i_mem_rdata : rd_reg;

    if ((i_instr.op == OP_MOV_A_R || i_instr.op == OP_MOV_R_A ||
         i_instr.op == OP_XCH_A_R) && i_instr.rsel == `TID_R_A) begin
      legal = 1'b0;
    end
    if (i_instr.op == OP_XCH_A_R && i_instr.rsel == `TID_R_X) begin
      legal = 1'b0;
    end
    if (op_saddr(i_instr.op) && (i_instr.loc < `TID_SADDR_LO ||
        i_instr.loc > `TID_SADDR_HI || (i_instr.wide && i_instr.loc[0]))) begin
      legal = 1'b0;
    end
    if (op_abs(i_instr.op) && i_instr.wide && i_instr.loc[0]) begin
      legal = 1'b0;
    end

    case (i_instr.op)
      OP_MOV_A_DE, OP_MOV_DE_A, OP_XCH_A_DE: begin
        ea_new = {gpr_reg[`TID_R_D], gpr_reg[`TID_R_E]};
      end
      OP_MOV_A_HL, OP_MOV_HL_A, OP_XCH_A_HL: begin
        ea_new = {gpr_reg[`TID_R_H], gpr_reg[`TID_R_L]};
      end
      OP_MOV_A_HLB, OP_MOV_HLB_A, OP_XCH_A_HLB: begin
        ea_new = {gpr_reg[`TID_R_H], gpr_reg[`TID_R_L]} +
                 {8'h00, i_instr.imm_byte};
      end
      default: begin
        if (op_sfr(i_instr.op)) begin
          ea_new = {`TID_SFR_PAGE, i_instr.sfr_sel};
        end
      end
    endcase

    case (st_reg)
      ST_IDLE: begin
        if (accept) begin
          len_next = op_len(i_instr.op);
          vec_next = `TID_VEC_BASE | {10'h000, i_instr.vec_sel, 1'b0};
          ill_next = !legal;
          if (legal) begin
            st_next = ST_EXEC;
            cnt_next = `TID_PH_FIRST;
            cyc_next = op_cyc(i_instr.op);
            cur_next = i_instr;
            ea_next = ea_new;
          end else begin
            done_next = 1'b1;
          end
        end
      end
      ST_EXEC: begin
        cnt_next = cnt_reg + `TID_CNT_ONE;
        if (cnt_reg == `TID_PH_REQ &&
            (op_rd(cur_reg.op) || op_wr(cur_reg.op))) begin
          mem_next.req = 1'b1;
          mem_next.we = op_wr(cur_reg.op);
          mem_next.sfr = op_sfr(cur_reg.op);
          mem_next.addr = ea_reg;
          mem_next.wdata = (cur_reg.op == OP_MOV_SADDR_IMM ||
                            cur_reg.op == OP_MOV_SFR_IMM) ?
                           cur_reg.imm_byte : acc;
        end
        if (cnt_reg == `TID_PH_DATA) begin
          rd_next = i_mem_rdata;
        end
        if (cnt_reg == `TID_PH_WB && op_xmem(cur_reg.op)) begin
          mem_next.req = 1'b1;
          mem_next.we = 1'b1;
          mem_next.sfr = op_sfr(cur_reg.op);
          mem_next.addr = ea_reg;
          mem_next.wdata = acc;
        end
        if (cnt_reg == cyc_reg - `TID_CNT_ONE) begin
          st_next = ST_IDLE;
          done_next = 1'b1;
          plo = {cur_reg.rpsel, 1'b0};
          phi = {cur_reg.rpsel, 1'b1};
          case (cur_reg.op)
            OP_MOV_R_IMM: gpr_next[cur_reg.rsel] = cur_reg.imm_byte;
            OP_MOV_A_R: gpr_next[`TID_R_A] = gpr_reg[cur_reg.rsel];
            OP_MOV_R_A: gpr_next[cur_reg.rsel] = acc;
            OP_MOV_PSW_IMM: psw_next = cur_reg.imm_byte;
            OP_MOV_PSW_A: psw_next = acc;
            OP_MOV_A_PSW: gpr_next[`TID_R_A] = psw_reg;
            OP_XCH_A_X: begin
              gpr_next[`TID_R_A] = gpr_reg[`TID_R_X];
              gpr_next[`TID_R_X] = acc;
            end
            OP_XCH_A_R: begin
              gpr_next[`TID_R_A] = gpr_reg[cur_reg.rsel];
              gpr_next[cur_reg.rsel] = acc;
            end
            OP_MOVW_RP_IMM: begin
              gpr_next[plo] = cur_reg.imm_word[7:0];
              gpr_next[phi] = cur_reg.imm_word[15:8];
            end
            default: begin
              if (op_rd(cur_reg.op)) begin
                gpr_next[`TID_R_A] = rd_val;
              end
            end
          endcase
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
    ready_next = (st_next == ST_IDLE);
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_reg <= ST_IDLE;
      cnt_reg <= '0;
      cyc_reg <= '0;
      cur_reg <= '0;
      ea_reg <= '0;
      rd_reg <= '0;
      gpr_reg <= '0;
      psw_reg <= `TID_PSW_RST;
      mem_reg <= '0;
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
      ill_reg <= 1'b0;
      len_reg <= '0;
      vec_reg <= '0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      cyc_reg <= cyc_next;
      cur_reg <= cur_next;
      ea_reg <= ea_next;
      rd_reg <= rd_next;
      gpr_reg <= gpr_next;
      psw_reg <= psw_next;
      mem_reg <= mem_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      ill_reg <= ill_next;
      len_reg <= len_next;
      vec_reg <= vec_next;
    end
  end

  assign o_ready = ready_reg;
  assign o_done = done_reg;
  assign o_illegal = ill_reg;
  assign o_len = len_reg;
  assign o_vec_loc = vec_reg;
  assign o_mem = mem_reg;
  assign o_gpr = gpr_reg;
  assign o_psw = psw_reg;
endmodule

// ---- verification/tid_mem_model.sv ----
// byte memory and special register space behind the decoder port
// assumes one-cycle read latency; only the low address byte is decoded
module tid_mem_model (
  // clock
  input wire logic i_clk_sys,
  // decoder side
  input wire tid_pkg::tid_mem_t i_mem,
  output logic [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  import tid_pkg::*;
  logic [7:0] mem [256];
  initial o_rdata = 8'h00;
  // read data lives one cycle; churn exposes late sampling
  always @(posedge i_clk_sys) begin
    if (i_mem.req && i_mem.we)
      mem[i_mem.addr[7:0]] <= i_mem.wdata;
    if (i_mem.req && !i_mem.we)
      o_rdata <= mem[i_mem.addr[7:0]];
    else
      o_rdata <= ~o_rdata;
  end
endmodule

// ---- verification/tid_checker_sva.sv ----
// timing assertions on the transfer decoder's ports
// assumes binding onto tid_decoder; one clock, async low reset
module tid_checker (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // watched ports
  input wire tid_pkg::tid_instr_t i_instr,
  input wire logic o_ready,
  input wire logic o_done,
  input wire logic o_illegal,
  input wire logic [15:0] o_vec_loc,
  input wire tid_pkg::tid_mem_t o_mem,
  input wire logic [7:0] o_psw
);
  timeunit 1ns;
  timeprecision 100ps;
  import tid_pkg::*;
  logic take;
  logic sd_in;
  assign take = i_instr.valid && o_ready;
  assign sd_in = i_instr.loc >= 16'hfe20 && i_instr.loc <= 16'hff1f;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);
  sequence s_rd;
    o_mem.req && !o_mem.we;
  endsequence
  sequence s_wr;
    o_mem.req && o_mem.we;
  endsequence
  property p_ill_reg;
    take && i_instr.rsel == 3'h1 && i_instr.op inside
      {OP_MOV_A_R, OP_MOV_R_A, OP_XCH_A_R} |=> o_done && o_illegal && o_ready;
  endproperty
  a_ill_reg: assert property (p_ill_reg) else $error("bad reg op");
  property p_sd_range;
    take && i_instr.op == OP_MOV_A_SADDR && !sd_in
      |=> o_done && o_illegal && !o_mem.req;
  endproperty
  a_sd_range: assert property (p_sd_range) else $error("range");
  property p_xchx;
    take && i_instr.op == OP_XCH_A_X |=> !o_done [*3] ##1 o_done;
  endproperty
  a_xchx: assert property (p_xchx) else $error("swap x time");
  property p_abs;
    take && i_instr.op == OP_MOV_ABS_A && !(i_instr.wide && i_instr.loc[0])
      |=> !o_done [*7] ##1 o_done;
  endproperty
  a_abs: assert property (p_abs) else $error("abs time");
  property p_imm;
    take && i_instr.op == OP_MOV_R_IMM |=> !o_done [*5] ##1 o_done;
  endproperty
  a_imm: assert property (p_imm) else $error("imm time");
  property p_swap;
    take && i_instr.op == OP_XCH_A_SADDR && sd_in && !i_instr.wide
      |=> !o_mem.req ##1 s_rd ##1 !o_mem.req ##1 s_wr ##1 !o_mem.req
      ##1 o_done;
  endproperty
  a_swap: assert property (p_swap) else $error("swap order");
  property p_vec;
    take |=> o_vec_loc == (16'h0040 | {10'h0, $past(i_instr.vec_sel), 1'b0});
  endproperty
  a_vec: assert property (p_vec) else $error("vector loc");
  property p_flags;
    take && !(i_instr.op inside {OP_MOV_PSW_IMM, OP_MOV_PSW_A})
      |=> $stable(o_psw) [*4];
  endproperty
  a_flags: assert property (p_flags) else $error("flags moved");
endmodule

bind tid_decoder tid_checker i_chk (.i_clk_sys, .i_reset_n, .i_instr,
  .o_ready, .o_done, .o_illegal, .o_vec_loc, .o_mem, .o_psw);

// ---- verification/test_transfer_instruction_decoder.sv ----
// self-checking bench for tid_decoder with a byte memory partner
// assumes tid_pkg, tid_mem_model and the checker are compiled first
module test_transfer_instruction_decoder;
  timeunit 1ns;
  timeprecision 100ps;
  import tid_pkg::*;
  typedef struct {
    tid_op_t op;
    int rsel;
    logic [7:0] ib;
    logic [15:0] loc;
    int wide, len, cyc, ill, idx;
    logic [7:0] val;
  } tid_row_t;
  logic i_clk_sys, i_reset_n, ready, done, illegal;
  logic [1:0] len;
  logic [7:0] rdata, status_word;
  tid_instr_t instr;
  tid_mem_t mem_bus;
  tid_gpr_t gpr;
  int fail_count, checked, cycles;
  // idx 0..7 register, 8 status word, 9 memory at loc
  tid_row_t rows [39] = '{
    '{OP_MOV_R_IMM, 1, 8'h3c, 16'h0, 0, 3, 6, 0, 1, 8'h3c},
    '{OP_MOV_R_IMM, 0, 8'ha5, 16'h0, 0, 3, 6, 0, 0, 8'ha5},
    '{OP_XCH_A_X, 0, 8'h00, 16'h0, 0, 1, 4, 0, 1, 8'ha5},
    '{OP_MOV_R_A, 7, 8'h00, 16'h0, 0, 2, 4, 0, 7, 8'ha5},
    '{OP_MOV_R_IMM, 6, 8'h20, 16'h0, 0, 3, 6, 0, 6, 8'h20},
    '{OP_MOV_A_HL, 0, 8'h00, 16'h0, 0, 1, 6, 0, 1, 8'h30},
    '{OP_MOV_SADDR_IMM, 0, 8'h77, 16'hfe40, 0, 3, 6, 0, 9, 8'h77},
    '{OP_XCH_A_SADDR, 0, 8'h00, 16'hfe40, 0, 2, 6, 0, 1, 8'h77},
    '{OP_MOV_A_SADDR, 0, 8'h00, 16'hfe40, 0, 2, 4, 0, 1, 8'h30},
    '{OP_MOV_ABS_A, 0, 8'h00, 16'h1234, 0, 3, 8, 0, 9, 8'h30},
    '{OP_MOV_PSW_IMM, 0, 8'h51, 16'h0, 0, 3, 6, 0, 8, 8'h51},
    '{OP_MOV_A_PSW, 0, 8'h00, 16'h0, 0, 2, 4, 0, 1, 8'h51},
    '{OP_MOVW_RP_IMM, 1, 8'h00, 16'hbeef, 0, 3, 6, 0, 3, 8'hbe},
    '{OP_XCH_A_HLB, 0, 8'h02, 16'h0, 0, 2, 8, 0, 1, 8'h32},
    '{OP_MOV_A_SFR, 0, 8'h30, 16'h0, 0, 2, 4, 0, 1, 8'h40},
    '{OP_MOV_PSW_A, 0, 8'h00, 16'h0, 0, 2, 4, 0, 8, 8'h40},
    '{OP_MOV_A_R, 1, 8'h00, 16'h0, 0, 2, 1, 1, 1, 8'h40},
    '{OP_XCH_A_R, 0, 8'h00, 16'h0, 0, 2, 1, 1, 1, 8'h40},
    '{OP_MOV_A_SADDR, 0, 8'h00, 16'hfe1f, 0, 2, 1, 1, 1, 8'h40},
    '{OP_MOV_A_SADDR, 0, 8'h00, 16'hfe21, 1, 2, 1, 1, 1, 8'h40},
    '{OP_MOV_A_ABS, 0, 8'h00, 16'h0101, 1, 3, 1, 1, 1, 8'h40},
    '{OP_MOV_A_SADDR, 0, 8'h00, 16'hff1f, 0, 2, 4, 0, 1, 8'h2f},
    '{OP_XCH_A_R, 2, 8'h00, 16'h0, 0, 2, 6, 0, 2, 8'h2f},
    '{OP_MOV_SFR_IMM, 0, 8'h45, 16'hff45, 0, 3, 6, 0, 9, 8'h45},
    '{OP_MOV_SFR_A, 0, 8'h46, 16'hff46, 0, 2, 4, 0, 9, 8'hef},
    '{OP_XCH_A_SFR, 0, 8'h47, 16'h0, 0, 2, 6, 0, 1, 8'h57},
    '{OP_MOV_A_SADDR, 0, 8'h00, 16'hfe47, 0, 2, 4, 0, 1, 8'hef},
    '{OP_MOV_SADDR_A, 0, 8'h00, 16'hfe48, 0, 2, 4, 0, 9, 8'hef},
    '{OP_MOVW_RP_IMM, 2, 8'h00, 16'h0060, 0, 3, 6, 0, 4, 8'h60},
    '{OP_MOV_DE_A, 0, 8'h00, 16'h0060, 0, 1, 6, 0, 9, 8'hef},
    '{OP_MOV_A_ABS, 0, 8'h00, 16'h1234, 0, 3, 8, 0, 1, 8'h30},
    '{OP_XCH_A_DE, 0, 8'h00, 16'h0, 0, 1, 8, 0, 1, 8'hef},
    '{OP_MOV_A_DE, 0, 8'h00, 16'h0, 0, 1, 6, 0, 1, 8'h30},
    '{OP_MOVW_RP_IMM, 3, 8'h00, 16'h0050, 0, 3, 6, 0, 6, 8'h50},
    '{OP_XCH_A_HL, 0, 8'h00, 16'h0, 0, 1, 8, 0, 1, 8'h60},
    '{OP_MOV_A_HLB, 0, 8'h00, 16'h0, 0, 2, 6, 0, 1, 8'h30},
    '{OP_MOV_HLB_A, 0, 8'h03, 16'h0053, 0, 2, 6, 0, 9, 8'h30},
    '{OP_MOVW_RP_IMM, 0, 8'h00, 16'h9a00, 0, 3, 6, 0, 1, 8'h9a},
    '{OP_MOV_HL_A, 0, 8'h00, 16'h0050, 0, 1, 6, 0, 9, 8'h9a}
  };

  tid_decoder i_dut (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_instr(instr),
    .o_ready(ready),
    .o_done(done),
    .o_illegal(illegal),
    .o_len(len),
    .o_vec_loc(),
    .o_mem(mem_bus),
    .i_mem_rdata(rdata),
    .o_gpr(gpr),
    .o_psw(status_word)
  );

  tid_mem_model i_mem (
    .i_clk_sys(i_clk_sys),
    .i_mem(mem_bus),
    .o_rdata(rdata)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // a hang costs one mismatch, then the normal report
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  function automatic logic [7:0] pick(input tid_row_t r);
    if (r.idx < 8)
      return gpr[r.idx];
    if (r.idx == 8)
      return status_word;
    return i_mem.mem[r.loc[7:0]];
  endfunction

  task automatic run_op(input tid_row_t r);
    tid_instr_t t;
    int n;
    t = '0;
    t.valid = 1'b1;
    t.op = r.op;
    t.rsel = 3'(r.rsel);
    t.rpsel = 2'(r.rsel);
    t.imm_byte = r.ib;
    t.imm_word = r.loc;
    t.loc = r.loc;
    t.sfr_sel = r.ib;
    t.vec_sel = r.ib[4:0];
    t.wide = r.wide[0];
    n = 0;
    while (ready !== 1'b1 && n < 50) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    @(posedge i_clk_sys);
    instr <= t;
    @(posedge i_clk_sys);
    instr.valid <= 1'b0;
    #1;
    n = 1;
    while (done !== 1'b1 && n < 20) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    chk(16'(r.cyc), 16'(n));
    chk(16'(r.len), {14'h0, len});
    chk(16'(r.ill), {15'h0, illegal});
    chk({8'h0, r.val}, {8'h0, pick(r)});
  endtask

  initial begin
    i_reset_n = 1'b0;
    instr = '0;
    fail_count = 0;
    checked = 0;
    cycles = 0;
    for (int k = 0; k < 256; k++)
      i_mem.mem[k] = 8'(k + 16);
    repeat (12) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    foreach (rows[k])
      run_op(rows[k]);
    $display("table test done");
    // reset lands while the last row is re-running
    @(posedge i_clk_sys);
    instr.valid <= 1'b1;
    @(posedge i_clk_sys);
    instr.valid <= 1'b0;
    @(posedge i_clk_sys);
    i_reset_n <= 1'b0;
    #1;
    chk(16'h0, {15'h0, ready});
    chk(16'h0002, {8'h0, status_word});
    chk(16'h0, {15'h0, mem_bus.req});
    chk(16'h1, {15'h0, gpr === '0});
    repeat (2) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    run_op(rows[0]);
    $display("reset test done");
    complete_run();
  end
endmodule
